// [pst_pkg.sv]
// constants and types for the status and telemetry register bank
package pst_pkg;
	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d; // temperature status byte
	localparam logic [7:0] CMD_COMM_STATUS = 8'h7e; // communication status byte
	localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80; // vendor fault byte
	localparam logic [7:0] CMD_VIN = 8'h88; // input voltage reading
	localparam logic [7:0] CMD_IIN = 8'h89; // input current reading
	// ----------------------------------------
	// bit positions
	// ----------------------------------------
	localparam int TEMP_OT_FAULT_BIT = 7;
	localparam int TEMP_OT_WARN_BIT = 6;
	localparam int COMM_BAD_CMD_BIT = 7;
	localparam int COMM_BAD_DATA_BIT = 6;
	localparam int COMM_PEC_BIT = 5;
	localparam int COMM_MEM_BIT = 4;
	localparam int COMM_OTHER_BIT = 1;
	localparam int VEND_PSTAGE_BIT = 7;
	localparam int VEND_PREBIAS_BIT = 6;
	localparam int VEND_ORST_BIT = 2;
	localparam int VEND_OMIN_BIT = 1;
	localparam int VEND_PHASE_BIT = 0;
	// ----------------------------------------
	// masks of implemented bits, resets
	// ----------------------------------------
	localparam logic [7:0] TEMP_IMPL_MASK = 8'hc0; // bits 5..0 read zero
	localparam logic [7:0] COMM_IMPL_MASK = 8'hf2; // bits 3,2,0 read zero
	localparam logic [7:0] VEND_IMPL_MASK = 8'hc7; // bits 5:3 read 000
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] READING_RESET = 16'h0000;
	localparam logic [15:0] READ_IDLE = 16'h0000; // data for unknown command
	// ----------------------------------------
	// linear format layout
	// ----------------------------------------
	localparam int LIN_EXP_LSB = 11;
	localparam int LIN_EXP_W = 5;
	localparam int LIN_MANT_W = 11;
	localparam int READ_LATENCY = 1; // cycles from request to data
	typedef logic [7:0] pst_byte_t;
endpackage : pst_pkg

// [pst_if.sv]
// carrier bundle for one linear-format reading
`timescale 1ns/100ps
`default_nettype none
interface pst_if;
	logic [4:0] exponent; // two's complement scale
	logic [10:0] mantissa; // two's complement value
	logic strobe; // new sample present
	logic [15:0] word; // packed linear word
	modport src (output exponent, output mantissa, output strobe, input word);
	modport pack (input exponent, input mantissa, input strobe, output word);
endinterface : pst_if
`default_nettype wire

// [pst_linear_reg.sv]
// holds one telemetry sample packed in linear format
`timescale 1ns/100ps
`default_nettype none
module pst_linear_reg (
	input wire logic clk,
	input wire logic reset,
	pst_if.pack lin
);
	import pst_pkg::*;
	// ----------------------------------------
	// sample store
	// ----------------------------------------
	// register keeps the last sample; never cleared by reads
	always_ff @(posedge clk) begin
		if (reset) begin
			lin.word <= READING_RESET;
		end else if (lin.strobe) begin
			lin.word <= {lin.exponent, lin.mantissa};
		end
	end
	a_pack_layout: assert property (@(posedge clk) disable iff (reset)
		lin.strobe |=> lin.word[15:11] == $past(lin.exponent)
		&& lin.word[10:0] == $past(lin.mantissa))
		else $error("linear word packing wrong");
endmodule : pst_linear_reg
`default_nettype wire

// [pst_status_bank.sv]
// status and telemetry register bank answering host reads by command code
`timescale 1ns/100ps
`default_nettype none
module pst_status_bank (
	input wire logic clk,
	input wire logic reset,
	// fault event pulses from detection logic
	input wire logic overheatFault,
	input wire logic overheatWarning,
	input wire logic badCommand,
	input wire logic badPayload,
	input wire logic packetCheckError,
	input wire logic hostWrite,
	input wire logic nvmBusy,
	input wire logic otherLinkError,
	input wire logic powerStageFault,
	input wire logic prebiasFault,
	input wire logic outputResetFault,
	input wire logic outputFloorFault,
	input wire logic missingPulseFault,
	input wire logic clearFaults,
	// telemetry samples
	input wire logic vinStrobe,
	input wire logic [4:0] vinExponent,
	input wire logic [10:0] vinMantissa,
	input wire logic iinStrobe,
	input wire logic [4:0] iinExponent,
	input wire logic [10:0] iinMantissa,
	// read port from the command decoder
	input wire logic readReq,
	input wire logic [7:0] readCmd,
	output logic [15:0] readData,
	output logic readValid,
	output logic readHit,
	output logic [7:0] tempStatus,
	output logic [7:0] commStatus,
	output logic [7:0] vendorStatus
);
	import pst_pkg::*;
	// ----------------------------------------
	// synchronisers for pin-level events
	// ----------------------------------------
	// fault lines come from analog/other blocks; two flops before use
	// write and busy are synced apart so no gate ever reads a raw pin
	localparam int NEV = 14;
	logic [NEV-1:0] evRaw; // raw event bundle
	logic [NEV-1:0] ev; // synchronised events
	logic memWriteHit; // host write while memory programs
	assign evRaw = {overheatFault, overheatWarning, badCommand, badPayload,
		packetCheckError, hostWrite, nvmBusy, otherLinkError, powerStageFault,
		prebiasFault, outputResetFault, outputFloorFault, missingPulseFault,
		clearFaults};
	// one two-stage capture per event line
	for (genvar i = 0; i < NEV; i++) begin : g_sync
		logic evMeta_r; // first stage, read only by second
		logic evSync_r; // second stage
		// first stage may go metastable, so nothing else looks at it
		always_ff @(posedge clk) begin
			if (reset) begin
				evMeta_r <= 1'b0;
				evSync_r <= 1'b0;
			end else begin
				evMeta_r <= evRaw[i];
				evSync_r <= evMeta_r;
			end
		end
		assign ev[i] = evSync_r;
	end
	// both lines high together once synchronised
	// trade-off: a one-cycle overlap may resolve apart and be missed
	assign memWriteHit = ev[8] & ev[7];
	// ----------------------------------------
	// event decode into byte-shaped set vectors
	// ----------------------------------------
	pst_byte_t tempSet; // temperature set bits
	pst_byte_t commSet; // communication set bits
	pst_byte_t vendSet; // vendor set bits
	logic clearSync; // synchronised clear command
	// place each event on its documented bit position
	always_comb begin
		tempSet = '0;
		commSet = '0;
		vendSet = '0;
		// temperature byte
		tempSet[TEMP_OT_FAULT_BIT] = ev[13];
		tempSet[TEMP_OT_WARN_BIT] = ev[12];
		// communication byte
		commSet[COMM_BAD_CMD_BIT] = ev[11];
		commSet[COMM_BAD_DATA_BIT] = ev[10];
		commSet[COMM_PEC_BIT] = ev[9];
		commSet[COMM_MEM_BIT] = memWriteHit;
		commSet[COMM_OTHER_BIT] = ev[6];
		// vendor byte
		vendSet[VEND_PSTAGE_BIT] = ev[5];
		vendSet[VEND_PREBIAS_BIT] = ev[4];
		vendSet[VEND_ORST_BIT] = ev[3];
		vendSet[VEND_OMIN_BIT] = ev[2];
		vendSet[VEND_PHASE_BIT] = ev[1];
	end
	assign clearSync = ev[0];
	// ----------------------------------------
	// latched status bytes
	// ----------------------------------------
	pst_byte_t temp_r; // temperature status
	pst_byte_t comm_r; // communication status
	pst_byte_t vend_r; // vendor fault status
	pst_byte_t temp_nxt;
	pst_byte_t comm_nxt;
	pst_byte_t vend_nxt;
	// set beats clear so an event in the clear cycle is kept
	// losing a fault that lands with a clear would hide it from the host
	always_comb begin
		temp_nxt = clearSync ? STATUS_RESET : temp_r;
		comm_nxt = clearSync ? STATUS_RESET : comm_r;
		vend_nxt = clearSync ? STATUS_RESET : vend_r;
		// unsupported positions masked so they never latch
		temp_nxt = (temp_nxt | tempSet) & TEMP_IMPL_MASK;
		comm_nxt = (comm_nxt | commSet) & COMM_IMPL_MASK;
		vend_nxt = (vend_nxt | vendSet) & VEND_IMPL_MASK;
	end
	// status bytes; reset to 00h
	always_ff @(posedge clk) begin
		if (reset) begin
			temp_r <= STATUS_RESET;
			comm_r <= STATUS_RESET;
			vend_r <= STATUS_RESET;
		end else begin
			temp_r <= temp_nxt;
			comm_r <= comm_nxt;
			vend_r <= vend_nxt;
		end
	end
	// ----------------------------------------
	// telemetry readings
	// ----------------------------------------
	pst_if vinLink ();
	pst_if iinLink ();
	// sample inputs are same-clock logic, no synchroniser
	// exponent and mantissa land in one word flop together,
	// so a reader never sees a torn pair from two samples
	assign vinLink.exponent = vinExponent;
	assign vinLink.mantissa = vinMantissa;
	assign vinLink.strobe = vinStrobe;
	assign iinLink.exponent = iinExponent;
	assign iinLink.mantissa = iinMantissa;
	assign iinLink.strobe = iinStrobe;
	pst_linear_reg uVin (
		.clk(clk),
		.reset(reset),
		.lin(vinLink.pack)
	);
	pst_linear_reg uIin (
		.clk(clk),
		.reset(reset),
		.lin(iinLink.pack)
	);
	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [15:0] readData_nxt; // selected answer
	logic readHit_nxt; // command recognised
	// reads only select; nothing here disturbs the flags
	always_comb begin
		readHit_nxt = 1'b1;
		case (readCmd)
			CMD_TEMP_STATUS: readData_nxt = {8'h00, temp_r};
			CMD_COMM_STATUS: readData_nxt = {8'h00, comm_r};
			CMD_VENDOR_STATUS: readData_nxt = {8'h00, vend_r};
			CMD_VIN: readData_nxt = vinLink.word;
			CMD_IIN: readData_nxt = iinLink.word;
			default: begin
				readData_nxt = READ_IDLE;
				readHit_nxt = 1'b0;
			end
		endcase
	end
	// answer registered one cycle after the request
	// data holds between requests so a slow host can still pick it up
	always_ff @(posedge clk) begin
		if (reset) begin
			readData <= READ_IDLE;
			readValid <= 1'b0;
			readHit <= 1'b0;
		end else begin
			readValid <= readReq;
			readHit <= readReq & readHit_nxt;
			if (readReq) begin
				readData <= readData_nxt;
			end
		end
	end
	// status mirrors held in flops of their own
	// loaded from the next value, so they track the bytes in step
	always_ff @(posedge clk) begin
		if (reset) begin
			tempStatus <= STATUS_RESET;
			commStatus <= STATUS_RESET;
			vendorStatus <= STATUS_RESET;
		end else begin
			tempStatus <= temp_nxt;
			commStatus <= comm_nxt;
			vendorStatus <= vend_nxt;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	// a pin event shows in its flag three edges later; a clear raised
	// later takes the same sync path, so it cannot undo the flag sooner
	a_otf_latch: assert property (@(posedge clk) disable iff (reset)
		overheatFault && !clearFaults
		|-> ##3 temp_r[7])
		else $error("overheat fault not latched");
	a_otw_latch: assert property (@(posedge clk) disable iff (reset)
		overheatWarning
		|-> ##3 temp_r[6])
		else $error("overheat warning not latched");
	// unsupported and reserved positions never hold a one
	a_zero_bits: assert property (@(posedge clk) disable iff (reset)
		temp_r[5:0] == 6'h00 && comm_r[3:2] == 2'h0 && !comm_r[0])
		else $error("unsupported bit set");
	a_vend_zero: assert property (@(posedge clk) disable iff (reset)
		vend_r[5:3] == 3'b000)
		else $error("sharing warning field nonzero");
	// registered answers carry the byte held at the request edge
	a_temp_read: assert property (@(posedge clk) disable iff (reset)
		readReq && readCmd == CMD_TEMP_STATUS
		|=> readValid && readData == {8'h00, $past(temp_r)})
		else $error("temperature byte read wrong");
	a_comm_read: assert property (@(posedge clk) disable iff (reset)
		readReq && readCmd == CMD_COMM_STATUS
		|=> readValid && readData == {8'h00, $past(comm_r)})
		else $error("comm byte read wrong");
	a_vend_read: assert property (@(posedge clk) disable iff (reset)
		readReq && readCmd == CMD_VENDOR_STATUS
		|=> readValid && readData == {8'h00, $past(vend_r)})
		else $error("vendor byte read wrong");
	a_vin_read: assert property (@(posedge clk) disable iff (reset)
		readReq && readCmd == CMD_VIN
		|=> readHit && readData == $past(vinLink.word))
		else $error("input voltage read wrong");
	a_iin_read: assert property (@(posedge clk) disable iff (reset)
		readReq && readCmd == CMD_IIN
		|=> readHit && readData == $past(iinLink.word))
		else $error("input current read wrong");
	// answer strobe is a single-cycle echo of the request
	a_read_strobe: assert property (@(posedge clk) disable iff (reset)
		readReq
		|=> readValid)
		else $error("read answer missing");
	a_read_quiet: assert property (@(posedge clk) disable iff (reset)
		!readReq
		|=> !readValid && !readHit)
		else $error("read answer without request");
	// unknown codes answer with no hit and an idle word
	a_miss_zero: assert property (@(posedge clk) disable iff (reset)
		readReq && readCmd != CMD_TEMP_STATUS && readCmd != CMD_COMM_STATUS
		&& readCmd != CMD_VENDOR_STATUS && readCmd != CMD_VIN && readCmd != CMD_IIN
		|=> !readHit && readData == READ_IDLE)
		else $error("unknown command answered");
	// the answer word holds until the next request
	a_data_holds: assert property (@(posedge clk) disable iff (reset)
		!readReq
		|=> $stable(readData))
		else $error("read data changed without request");
	// communication flags, one line each, two for the memory flag
	a_bad_cmd: assert property (@(posedge clk) disable iff (reset)
		badCommand
		|-> ##3 comm_r[7])
		else $error("bad command not latched");
	a_bad_data: assert property (@(posedge clk) disable iff (reset)
		badPayload
		|-> ##3 comm_r[6])
		else $error("bad payload not latched");
	a_packet_check_error_flag: assert property (@(posedge clk) disable iff (reset)
		packetCheckError
		|-> ##3 comm_r[5])
		else $error("packet check error not latched");
	a_mem_busy: assert property (@(posedge clk) disable iff (reset)
		hostWrite && nvmBusy
		|-> ##3 comm_r[4])
		else $error("memory busy write not latched");
	a_link_other: assert property (@(posedge clk) disable iff (reset)
		otherLinkError
		|-> ##3 comm_r[1])
		else $error("other link error not latched");
	// set beats clear when both arrive in one cycle
	a_set_wins: assert property (@(posedge clk) disable iff (reset)
		clearSync && commSet[COMM_BAD_CMD_BIT]
		|=> comm_r[COMM_BAD_CMD_BIT])
		else $error("set lost to clear");
	// vendor flags, one line each
	a_stage_fault: assert property (@(posedge clk) disable iff (reset)
		powerStageFault
		|-> ##3 vend_r[7])
		else $error("power stage fault not latched");
	a_prebias_fault: assert property (@(posedge clk) disable iff (reset)
		prebiasFault
		|-> ##3 vend_r[6])
		else $error("prebias fault not latched");
	a_out_reset: assert property (@(posedge clk) disable iff (reset)
		outputResetFault
		|-> ##3 vend_r[2])
		else $error("output reset fault not latched");
	a_out_floor: assert property (@(posedge clk) disable iff (reset)
		outputFloorFault
		|-> ##3 vend_r[1])
		else $error("output floor fault not latched");
	a_phase_fault: assert property (@(posedge clk) disable iff (reset)
		missingPulseFault
		|-> ##3 vend_r[0])
		else $error("missing pulse fault not latched");
	// reset empties every byte, checked one edge after reset is sampled high
	a_reset_clear: assert property (@(posedge clk)
		reset
		|=> temp_r == STATUS_RESET && comm_r == STATUS_RESET && vend_r == STATUS_RESET)
		else $error("status byte not empty after reset");
	// a clear with no event in flight empties every byte
	a_clear_empties: assert property (@(posedge clk) disable iff (reset)
		clearSync && tempSet == 8'h00 && commSet == 8'h00 && vendSet == 8'h00
		|=> temp_r == STATUS_RESET && comm_r == STATUS_RESET
		&& vend_r == STATUS_RESET)
		else $error("clear left a flag set");
	// mirrors follow the internal bytes every cycle
	a_mirror_track: assert property (@(posedge clk) disable iff (reset)
		tempStatus == temp_r && commStatus == comm_r
		&& vendorStatus == vend_r)
		else $error("status mirror out of step");
	// reads never drop a flag; only a clear does
	a_read_keeps: assert property (@(posedge clk) disable iff (reset)
		temp_r[7] && !clearSync
		|=> temp_r[7])
		else $error("flag dropped without clear");
	a_comm_keeps: assert property (@(posedge clk) disable iff (reset)
		comm_r[7] && !clearSync
		|=> comm_r[7])
		else $error("comm flag dropped without clear");
	a_vend_keeps: assert property (@(posedge clk) disable iff (reset)
		vend_r[0] && !clearSync
		|=> vend_r[0])
		else $error("vendor flag dropped without clear");
endmodule : pst_status_bank
`default_nettype wire

// [pst_host_model.sv]
// host-side model that reads status and telemetry from the bank
`timescale 1ns/100ps
`default_nettype none
module pst_host_model (
	input wire logic clk,
	input wire logic [15:0] readData,
	input wire logic readValid,
	input wire logic readHit,
	output logic readReq,
	output logic [7:0] readCmd
);
	// idle bus at time zero
	initial begin
		readReq = 1'b0;
		readCmd = 8'h00;
	end
	// ----------------------------------------
	// one read transaction
	// ----------------------------------------
	// the request is held through its sampling edge; the answer is taken just after that same edge.
	// only reads are issued here; host writes while memory programs come from the bench's event pins
	task automatic doRead(input logic [7:0] cmd, output logic [15:0] data,
		output logic hit, output logic valid);
		@(posedge clk);
		#1;
		readReq = 1'b1;
		readCmd = cmd;
		@(posedge clk);
		#1;
		readReq = 1'b0;
		readCmd = ~cmd; // released command changes so a stale decode shows
		data = readData;
		hit = readHit;
		valid = readValid;
	endtask : doRead
endmodule : pst_host_model
`default_nettype wire

// [pst_status_bank_tb_top.sv]
// self-checking bench for the status and telemetry bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin fails++; \
	$display("Error %s expected %h seen %h", nm, ex, gt); end end
module pst_status_bank_tb_top;
	import pst_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [12:0] ev = '0; // event pins, one bit each
	logic clearFaults = 1'b0;
	logic vinStrobe = 1'b0;
	logic iinStrobe = 1'b0;
	logic [4:0] vinExponent = '0;
	logic [10:0] vinMantissa = '0;
	logic [4:0] iinExponent = '0;
	logic [10:0] iinMantissa = '0;
	logic readReq, readValid, readHit;
	logic [7:0] readCmd, tempStatus, commStatus, vendorStatus;
	logic [15:0] readData;
	logic [23:0] expSt; // expected {vendor, comm, temp}
	int fails = 0;
	int checksDone = 0;
	int cycles = 0;
	// event pin and the {vendor, comm, temp} bits it must latch
	localparam logic [12:0] EV [14] = '{13'h0001, 13'h0002, 13'h0004, 13'h0008, 13'h0010,
		13'h0020, 13'h0040, 13'h0060, 13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800, 13'h1000};
	localparam logic [23:0] ADD [14] = '{24'h000080, 24'h000040, 24'h008000, 24'h004000,
		24'h002000, 24'h000000, 24'h000000, 24'h001000, 24'h000200, 24'h800000, 24'h400000,
		24'h040000, 24'h020000, 24'h010000};
	always #50 clk = ~clk;
	pst_status_bank uut (.clk(clk), .reset(reset), .overheatFault(ev[0]),
		.overheatWarning(ev[1]), .badCommand(ev[2]), .badPayload(ev[3]),
		.packetCheckError(ev[4]), .hostWrite(ev[5]), .nvmBusy(ev[6]),
		.otherLinkError(ev[7]), .powerStageFault(ev[8]), .prebiasFault(ev[9]),
		.outputResetFault(ev[10]), .outputFloorFault(ev[11]), .missingPulseFault(ev[12]),
		.clearFaults(clearFaults), .vinStrobe(vinStrobe), .vinExponent(vinExponent),
		.vinMantissa(vinMantissa), .iinStrobe(iinStrobe), .iinExponent(iinExponent),
		.iinMantissa(iinMantissa), .readReq(readReq), .readCmd(readCmd),
		.readData(readData), .readValid(readValid), .readHit(readHit),
		.tempStatus(tempStatus), .commStatus(commStatus), .vendorStatus(vendorStatus));
	pst_host_model host (.clk(clk), .readData(readData), .readValid(readValid),
		.readHit(readHit), .readReq(readReq), .readCmd(readCmd));
	// ----------------------------------------
	// shared checks
	// ----------------------------------------
	// read one command and judge data, hit and the answer strobe
	task automatic rdChk(input logic [7:0] cmd, input logic [15:0] ex, input logic exHit);
		logic [15:0] d;
		logic h, v;
		host.doRead(cmd, d, h, v);
		`CHK("readValid", 1'b1, v)
		`CHK("readHit", exHit, h)
		`CHK("readData", ex, d)
		@(posedge clk);
		#1;
		`CHK("readValid low", 1'b0, readValid)
		`CHK("readData held", ex, readData)
	endtask : rdChk
	// all three bytes by command and by mirror outputs
	task automatic statusChk();
		rdChk(CMD_TEMP_STATUS, {8'h00, expSt[7:0]}, 1'b1);
		rdChk(CMD_COMM_STATUS, {8'h00, expSt[15:8]}, 1'b1);
		rdChk(CMD_VENDOR_STATUS, {8'h00, expSt[23:16]}, 1'b1);
		`CHK("mirrors", expSt, {vendorStatus, commStatus, tempStatus})
	endtask : statusChk
	// pulse pins for one cycle, then let the sync stages settle
	task automatic pulse(input logic [12:0] e, input logic clr);
		ev = e;
		clearFaults = clr;
		@(posedge clk);
		#1;
		ev = '0;
		clearFaults = 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask : pulse
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset values, readings at zero, unknown commands refused
	task automatic tReset();
		expSt = '0;
		statusChk();
		rdChk(CMD_VIN, READING_RESET, 1'b1);
		rdChk(CMD_IIN, READING_RESET, 1'b1);
		rdChk(8'h7c, READ_IDLE, 1'b0);
		rdChk(8'h8b, READ_IDLE, 1'b0);
		$display("test reset done");
	endtask : tReset
	// every fault pin latches its own bit only, write and busy only as a pair; reads never clear
	task automatic tEvents();
		for (int i = 0; i < 14; i++) begin
			pulse(EV[i], 1'b0);
			expSt |= ADD[i];
			statusChk();
		end
		statusChk();
		$display("test events done");
	endtask : tEvents
	// clear empties all bytes; a set in the clear cycle wins
	task automatic tClear();
		pulse('0, 1'b1);
		expSt = '0;
		statusChk();
		pulse(13'h0004, 1'b1);
		expSt = 24'h008000;
		statusChk();
		$display("test clear done");
	endtask : tClear
	// linear words carry extreme signed exponents and an all-ones or minimum mantissa
	task automatic tTelemetry();
		vinStrobe = 1'b1;
		vinExponent = 5'h10;
		vinMantissa = 11'h7ff;
		iinStrobe = 1'b1;
		iinExponent = 5'h0f;
		iinMantissa = 11'h400;
		@(posedge clk);
		#1;
		vinStrobe = 1'b0;
		iinStrobe = 1'b0;
		rdChk(CMD_VIN, {5'h10, 11'h7ff}, 1'b1);
		rdChk(CMD_IIN, {5'h0f, 11'h400}, 1'b1);
		$display("test telemetry done");
	endtask : tTelemetry
	// every flag and both readings set, then a mid-run reset empties them
	task automatic tMidReset();
		pulse(13'h1fff, 1'b0);
		expSt = 24'hc7f2c0;
		statusChk();
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		expSt = '0;
		statusChk();
		rdChk(CMD_VIN, READING_RESET, 1'b1);
		rdChk(CMD_IIN, READING_RESET, 1'b1);
		$display("test mid reset done");
	endtask : tMidReset
	// ----------------------------------------
	// verdict and run control
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	// hang guard: whole run is a few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		tReset();
		tEvents();
		tClear();
		tTelemetry();
		tMidReset();
		finish_test();
	end
endmodule : pst_status_bank_tb_top
`default_nettype wire
